// *** logic/otr_cfg.svh ***
// Register map, reset values and timing constants for the termination mask and thermal readout
// Summary of operation
// - Write to rank drives its write mask
// - Write masks: two words, byte per rank
// - Read from rank drives its read mask
// - Read masks packed same as write masks
// - Write masks reset one-hot on own rank
// - Read masks reset to zero
// - Mask registers accessible in every state
// - Readout returns latest polled temperature
// - Readout read-only, ignores writes, resets zero
// - Rank n value at bits 4n+1:4n
// - Rank n status flag at bit 4n+2
// - Termination timed from chip select, on/off delays
`ifndef OTR_CFG_SVH
`define OTR_CFG_SVH
// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define OTR_OFS_WR_LO 12'h360
`define OTR_OFS_WR_HI 12'h364
`define OTR_OFS_RD_LO 12'h368
`define OTR_OFS_RD_HI 12'h36C
`define OTR_OFS_THERM 12'h370
`define OTR_OFS_TIMING 12'h358
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define OTR_RST_WR_LO 32'h08040201
`define OTR_RST_WR_HI 32'h80402010
`define OTR_RST_RD_LO 32'h00000000
`define OTR_RST_RD_HI 32'h00000000
`define OTR_RST_THERM 32'h00000000
`define OTR_RST_TIMING 32'h06000600
// ------------------------------------------------------------
// Field positions of the on/off delay register
// ------------------------------------------------------------
`define OTR_TON_WR_LSB 0
`define OTR_TOFF_WR_LSB 8
`define OTR_TON_RD_LSB 16
`define OTR_TOFF_RD_LSB 24
`define OTR_DLY_W 5
// ------------------------------------------------------------
// Readout nibble layout
// ------------------------------------------------------------
`define OTR_NIB_W 4
`define OTR_FLAG_POS 2
`endif

// *** logic/otr_pkg.sv ***
// Types shared by the termination mask and thermal readout block
package otr_pkg;
   // Access kind of the current column command
   typedef enum logic [1:0]
   {
      OTR_IDLE = 2'b00,
      OTR_WR = 2'b01,
      OTR_RD = 2'b11
   } otr_kind_t;
endpackage

// *** logic/otr_thermal_store.sv ***
// Per-rank thermal poll result store with registered read data
`timescale 1ns/10ps
`default_nettype none
`include "otr_cfg.svh"
module otr_thermal_store
#(
   parameter int RANKS = 8
)
(
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic [RANKS-1:0] upd_i,
   input wire logic [2*RANKS-1:0] value_i,
   input wire logic [RANKS-1:0] flag_i,
   input wire logic rd_i,
   output logic [4*RANKS-1:0] rdata_o
);
   // All rank nibbles side by side, rank 0 lowest
   wire logic [4*RANKS-1:0] store_all;

   // ------------------------------------------------------------
   // Per-rank capture
   // ------------------------------------------------------------
   for (genvar n = 0; n < RANKS; n++)
   begin : g_rank
      // Stored nibble of this rank
      logic [3:0] nib_q;

      // Latest poll wins; software cannot write here
      always_ff @(posedge mclk_i)
      begin
         if (!resetn_i)
         begin
            nib_q <= 4'h0;
         end
         else if (upd_i[n])
         begin
            nib_q[1:0] <= value_i[2*n +: 2];
            nib_q[`OTR_FLAG_POS] <= flag_i[n];
            nib_q[3] <= 1'b0;
         end
      end

      // Each rank owns its slice, so no variable has two writers
      assign store_all[4*n +: 4] = nib_q;
   end

   // Registered read port
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         rdata_o <= '0;
      end
      else if (rd_i)
      begin
         rdata_o <= store_all;
      end
   end
endmodule
`default_nettype wire

// *** logic/otr_top.sv ***
// Termination mask registers, on-die termination timing and thermal readout
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "otr_cfg.svh"
module otr_top
#(
   parameter int RANKS = 8
)
(
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   input wire logic cmd_valid_i,
   input wire otr_pkg::otr_kind_t cmd_kind_i,
   input wire logic [2:0] cmd_rank_i,
   input wire logic [RANKS-1:0] poll_upd_i,
   input wire logic [2*RANKS-1:0] poll_value_i,
   input wire logic [RANKS-1:0] poll_flag_i,
   output logic [7:0] dfi_odt_o
);
   import otr_pkg::*;

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (RANKS != 8)
   begin : g_bad_ranks
      $error("otr_top serves exactly eight ranks");
   end

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [31:0] wr_lo_q; // Write masks ranks 0-3
   logic [31:0] wr_hi_q; // Write masks ranks 4-7
   logic [31:0] rd_lo_q; // Read masks ranks 0-3
   logic [31:0] rd_hi_q; // Read masks ranks 4-7
   logic [31:0] tim_q; // On/off delays
   logic [63:0] wr_all; // All write masks
   logic [63:0] rd_all; // All read masks
   logic [7:0] mask_q; // Mask latched at command
   logic [4:0] on_q; // On delay of the access
   logic [4:0] off_q; // Off delay of the access
   logic [4:0] cnt_q; // Cycles since chip select
   logic busy_q; // Access window open
   logic sel_q; // Previous cycle carried a read of any address
   logic therm_sel_q; // Previous read was the readout
   logic [31:0] rdata_d; // Read mux
   logic [31:0] rdata_q; // Registered read mux
   logic [31:0] therm_rdata; // Readout store data
   logic therm_rd; // Readout read strobe

   assign wr_all = {wr_hi_q, wr_lo_q};
   assign rd_all = {rd_hi_q, rd_lo_q};
   assign therm_rd = reg_rd_i && (reg_addr_i == `OTR_OFS_THERM);

   // ------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------
   // Write masks; accepted in any controller state
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         wr_lo_q <= `OTR_RST_WR_LO;
         wr_hi_q <= `OTR_RST_WR_HI;
      end
      else if (reg_wr_i)
      begin
         if (reg_addr_i == `OTR_OFS_WR_LO)
         begin
            wr_lo_q <= reg_wdata_i;
         end
         else if (reg_addr_i == `OTR_OFS_WR_HI)
         begin
            wr_hi_q <= reg_wdata_i;
         end
      end
   end

   // Read masks
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         rd_lo_q <= `OTR_RST_RD_LO;
         rd_hi_q <= `OTR_RST_RD_HI;
      end
      else if (reg_wr_i)
      begin
         if (reg_addr_i == `OTR_OFS_RD_LO)
         begin
            rd_lo_q <= reg_wdata_i;
         end
         else if (reg_addr_i == `OTR_OFS_RD_HI)
         begin
            rd_hi_q <= reg_wdata_i;
         end
      end
   end

   // Delay register; reserved bits held at zero
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         tim_q <= `OTR_RST_TIMING;
      end
      else if (reg_wr_i && (reg_addr_i == `OTR_OFS_TIMING))
      begin
         tim_q <= reg_wdata_i & 32'h1F1F1F1F;
      end
   end

   // ------------------------------------------------------------
   // Termination timing
   // ------------------------------------------------------------
   // Latch mask and delays when chip select fires
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         mask_q <= 8'h00;
         on_q <= 5'h00;
         off_q <= 5'h00;
      end
      else if (cmd_valid_i && (cmd_kind_i == OTR_WR))
      begin
         mask_q <= wr_all[8*cmd_rank_i +: 8];
         on_q <= tim_q[`OTR_TON_WR_LSB +: `OTR_DLY_W];
         off_q <= tim_q[`OTR_TOFF_WR_LSB +: `OTR_DLY_W];
      end
      else if (cmd_valid_i && (cmd_kind_i == OTR_RD))
      begin
         mask_q <= rd_all[8*cmd_rank_i +: 8];
         on_q <= tim_q[`OTR_TON_RD_LSB +: `OTR_DLY_W];
         off_q <= tim_q[`OTR_TOFF_RD_LSB +: `OTR_DLY_W];
      end
   end

   // Cycle counter from chip select; a new write or read command restarts it
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         cnt_q <= 5'h00;
         busy_q <= 1'b0;
      end
      else if (cmd_valid_i && (cmd_kind_i != OTR_IDLE))
      begin
         cnt_q <= 5'h00;
         busy_q <= 1'b1;
      end
      else if (busy_q)
      begin
         cnt_q <= cnt_q + 5'h01;
         if (cnt_q == 5'h1F)
         begin
            busy_q <= 1'b0;
         end
      end
   end

   // Drive termination inside the on/off window
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         dfi_odt_o <= 8'h00;
      end
      else if (busy_q && (cnt_q == on_q))
      begin
         dfi_odt_o <= mask_q;
      end
      else if (busy_q && (cnt_q == off_q))
      begin
         dfi_odt_o <= 8'h00;
      end
      else if (!busy_q)
      begin
         dfi_odt_o <= 8'h00;
      end
   end

   // ------------------------------------------------------------
   // Thermal readout store
   // ------------------------------------------------------------
   otr_thermal_store #(.RANKS(RANKS)) u_store
   (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .upd_i(poll_upd_i),
      .value_i(poll_value_i),
      .flag_i(poll_flag_i),
      .rd_i(therm_rd),
      .rdata_o(therm_rdata)
   );

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   // Select data for a read; unmapped reads give zero
   always_comb
   begin
      rdata_d = 32'h00000000;
      unique case (reg_addr_i)
         `OTR_OFS_WR_LO: rdata_d = wr_lo_q;
         `OTR_OFS_WR_HI: rdata_d = wr_hi_q;
         `OTR_OFS_RD_LO: rdata_d = rd_lo_q;
         `OTR_OFS_RD_HI: rdata_d = rd_hi_q;
         `OTR_OFS_TIMING: rdata_d = tim_q;
         default: rdata_d = 32'h00000000;
      endcase
   end

   // Register mux data and remember the source
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         rdata_q <= 32'h00000000;
         sel_q <= 1'b0;
         therm_sel_q <= 1'b0;
      end
      else
      begin
         rdata_q <= reg_rd_i ? rdata_d : 32'h00000000;
         sel_q <= reg_rd_i;
         therm_sel_q <= therm_rd;
      end
   end

   // Readout data already registered in the store; merge both sources
   always_comb
   begin
      reg_rdata_o = 32'h00000000;
      if (therm_sel_q)
      begin
         reg_rdata_o = therm_rdata;
      end
      else if (sel_q)
      begin
         reg_rdata_o = rdata_q;
      end
   end
endmodule
`default_nettype wire

// *** verif/otr_props.sv ***
// Port checker for the termination mask and thermal readout block
`timescale 1ns/10ps
`default_nettype none
module otr_props
#(
   parameter int RANKS = 8
)
(
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic cmd_valid_i,
   input wire otr_pkg::otr_kind_t cmd_kind_i,
   input wire logic [RANKS-1:0] poll_upd_i,
   input wire logic [2*RANKS-1:0] poll_value_i,
   input wire logic [RANKS-1:0] poll_flag_i,
   input wire logic [7:0] dfi_odt_o
);
   import otr_pkg::*;
   logic [5:0] since_q; // Cycles since the last write or read command
   logic [2:0] cap0_q; // Poll flag and value of rank 0 seen last edge
   logic [2:0] cap7_q; // Poll flag and value of rank 7 seen last edge
   // Age counter, saturates so old commands never wrap back in
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
         since_q <= 6'h3F;
      else if (cmd_valid_i && cmd_kind_i != OTR_IDLE)
         since_q <= 6'h00;
      else if (since_q != 6'h3F)
         since_q <= since_q + 6'h01;
   end
   // Poll inputs of the outer ranks, one edge late
   always_ff @(posedge mclk_i)
   begin
      cap0_q <= {poll_flag_i[0], poll_value_i[1:0]};
      cap7_q <= {poll_flag_i[7], poll_value_i[15:14]};
   end
   default clocking @(posedge mclk_i);
   endclocking
   default disable iff (!resetn_i);
   rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
      else $error("read data outside its cycle");
   spare_zero_a: assert property (reg_rd_i && reg_addr_i == 12'h370
      |=> (reg_rdata_o & 32'h88888888) == 32'h0) else $error("spare thermal bit set");
   odt_window_a: assert property (dfi_odt_o != 8'h00 |-> since_q <= 6'd35)
      else $error("termination without recent command");
   therm_stable_a: assert property (reg_rd_i && reg_addr_i == 12'h370 && poll_upd_i == 8'h00
      ##1 reg_rd_i && reg_addr_i == 12'h370 |=> $stable(reg_rdata_o))
      else $error("thermal readout changed without poll");
   poll_r0_a: assert property (poll_upd_i[0] ##1 reg_rd_i && reg_addr_i == 12'h370
      && !poll_upd_i[0] |=> reg_rdata_o[2:0] == $past(cap0_q)) else $error("rank 0 poll lost");
   poll_r7_a: assert property (poll_upd_i[7] ##1 reg_rd_i && reg_addr_i == 12'h370
      && !poll_upd_i[7] |=> reg_rdata_o[30:28] == $past(cap7_q)) else $error("rank 7 poll lost");
   wr_back_a: assert property (reg_wr_i && reg_addr_i == 12'h360 ##1 reg_rd_i
      && reg_addr_i == 12'h360 |=> reg_rdata_o == $past(reg_wdata_i, 2))
      else $error("write mask readback");
   rd_back_a: assert property (reg_wr_i && reg_addr_i == 12'h36C ##1 reg_rd_i
      && reg_addr_i == 12'h36C |=> reg_rdata_o == $past(reg_wdata_i, 2))
      else $error("read mask readback");
   // Main scenarios reached
   odt_on_c: cover property (cmd_valid_i && cmd_kind_i == OTR_RD ##4 dfi_odt_o != 8'h00);
   therm_rd_c: cover property (poll_upd_i[7] ##1 reg_rd_i && reg_addr_i == 12'h370);
   rd_pair_c: cover property (reg_rd_i ##1 reg_rd_i);
endmodule
bind otr_top otr_props #(.RANKS(RANKS)) chk_u (.mclk_i(mclk_i), .resetn_i(resetn_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .cmd_valid_i(cmd_valid_i),
   .cmd_kind_i(cmd_kind_i), .poll_upd_i(poll_upd_i), .poll_value_i(poll_value_i),
   .poll_flag_i(poll_flag_i), .dfi_odt_o(dfi_odt_o));
`default_nettype wire

// *** verif/otr_phy_model.sv ***
// Behavioural PHY that samples the termination pattern it receives
`timescale 1ns/10ps
`default_nettype none
module otr_phy_model
(
   input wire logic mclk_i,
   input wire logic [7:0] dfi_odt_i,
   output logic [7:0] odt_seen_o
);
   // PHY takes the pattern on every rising edge
   always_ff @(posedge mclk_i)
   begin
      odt_seen_o <= dfi_odt_i;
   end
endmodule
`default_nettype wire

// *** verif/test_odt_mask_and_temp_readout.sv ***
// Self-checking bench for the termination mask and thermal readout block
`timescale 1ns/10ps
`default_nettype none
module test_odt_mask_and_temp_readout;
   import otr_pkg::*;
   logic mclk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [11:0] reg_addr_i = 12'h000;
   logic [31:0] reg_wdata_i = 32'h0;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [31:0] reg_rdata_o;
   logic cmd_valid_i = 1'b0;
   otr_kind_t cmd_kind_i = OTR_IDLE;
   logic [2:0] cmd_rank_i = 3'h0;
   logic [7:0] poll_upd_i = 8'h00;
   logic [15:0] poll_value_i = 16'h0000;
   logic [7:0] poll_flag_i = 8'h00;
   logic [7:0] dfi_odt_o;
   logic [7:0] odt_seen; // Pattern as the PHY took it
   logic [63:0] wmask = 64'hFF00A55A_C33C0180; // Write patterns, rank 0 lowest
   logic [63:0] rmask = 64'h3CFF1234_5AA5C3FE; // Read patterns, rank 0 lowest
   logic [31:0] exp_th = 32'h0; // Expected thermal readout
   int n_fail = 0;
   int tests_run = 0;
   always #20 mclk_i = ~mclk_i;
   otr_top #(.RANKS(8)) dut_u (.mclk_i(mclk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .cmd_valid_i(cmd_valid_i), .cmd_kind_i(cmd_kind_i),
      .cmd_rank_i(cmd_rank_i), .poll_upd_i(poll_upd_i), .poll_value_i(poll_value_i),
      .poll_flag_i(poll_flag_i), .dfi_odt_o(dfi_odt_o));
   otr_phy_model phy_u (.mclk_i(mclk_i), .dfi_odt_i(dfi_odt_o), .odt_seen_o(odt_seen));
   // Compare a register word
   task automatic chk32(string nm, logic [31:0] exp, logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Compare a termination pattern
   task automatic chk8(string nm, logic [7:0] exp, logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One bus cycle; strobe stays up so accesses run back to back
   task automatic acc(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge mclk_i);
      reg_wr_i <= w;
      reg_rd_i <= !w;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      poll_upd_i <= 8'h00;
   endtask
   // Read, then check the word in the cycle after the strobe
   task automatic rd(logic [11:0] a, logic [31:0] exp);
      acc(1'b0, a, 32'h0);
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      #1 chk32("rdata", exp, reg_rdata_o);
   endtask
   // Column command, then look at what the PHY got inside the window
   task automatic cmd(otr_kind_t k, logic [2:0] r, logic [7:0] exp);
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b0;
      cmd_valid_i <= 1'b1;
      cmd_kind_i <= k;
      cmd_rank_i <= r;
      @(posedge mclk_i);
      cmd_valid_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      #1 chk8("dfi_odt", exp, odt_seen);
      repeat (10) @(posedge mclk_i);
      // Window must be closed again well before the next command
      #1 chk8("dfi_odt_off", 8'h00, odt_seen);
   endtask
   // Poll result for the ranks in u, then read it back at once
   task automatic poll(logic [7:0] u, logic [15:0] v, logic [7:0] f);
      @(posedge mclk_i);
      poll_upd_i <= u;
      poll_value_i <= v;
      poll_flag_i <= f;
      for (int n = 0; n < 8; n++)
         if (u[n])
            exp_th[4*n+:4] = {1'b0, f[n], v[2*n+:2]};
      rd(12'h370, exp_th);
   endtask
   // Closing report
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Hang guard
   initial
   begin
      repeat (20000) @(posedge mclk_i);
      n_fail++;
      print_verdict();
   end
   // Main sequence
   initial
   begin
      repeat (6) @(posedge mclk_i);
      resetn_i <= 1'b1;
      rd(12'h360, 32'h08040201);
      rd(12'h364, 32'h80402010);
      rd(12'h368, 32'h00000000);
      rd(12'h36C, 32'h00000000);
      rd(12'h370, 32'h00000000);
      rd(12'h358, 32'h06000600);
      cmd(OTR_WR, 3'h3, 8'h08);
      cmd(OTR_RD, 3'h5, 8'h00);
      $display("test reset_values done");
      acc(1'b1, 12'h364, wmask[63:32]);
      acc(1'b1, 12'h368, rmask[31:0]);
      acc(1'b1, 12'h36C, rmask[63:32]);
      rd(12'h36C, rmask[63:32]);
      acc(1'b1, 12'h360, wmask[31:0]);
      rd(12'h360, wmask[31:0]);
      rd(12'h364, wmask[63:32]);
      rd(12'h368, rmask[31:0]);
      $display("test mask_access done");
      for (int r = 0; r < 8; r++)
      begin
         cmd(OTR_WR, r[2:0], wmask[8*r+:8]);
         cmd(OTR_RD, r[2:0], rmask[8*r+:8]);
      end
      // Last mask latched is non-zero, so a restarted window would show
      cmd(OTR_IDLE, 3'h2, 8'h00);
      // On delay 4, off delay 5 for writes; reserved bits must drop
      acc(1'b1, 12'h358, 32'hE6E0E504);
      rd(12'h358, 32'h06000504);
      // Termination not yet on four cycles after the command
      cmd(OTR_WR, 3'h2, 8'h00);
      $display("test termination done");
      poll(8'hFF, 16'hE4E4, 8'hA5);
      poll(8'h80, 16'hC000, 8'h80);
      acc(1'b1, 12'h370, 32'hFFFFFFFF);
      acc(1'b0, 12'h370, 32'h0);
      rd(12'h370, exp_th);
      poll(8'h01, 16'h0003, 8'h01);
      rd(12'h3F0, 32'h0);
      $display("test thermal done");
      print_verdict();
   end
endmodule
`default_nettype wire
